//--- hw/adcsq_pkg.sv
package adcsq_pkg;
  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] ADDR_RESULT_LOW = 8'h24;
  localparam logic [7:0] ADDR_RESULT_HIGH = 8'h25;
  localparam logic [7:0] ADDR_CONTROL = 8'h26;
  localparam logic [7:0] ADDR_CLOCK_SETTING = 8'h27;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h28;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h2C;

  // ****************************************
  // field positions
  // ****************************************
  localparam int CHANNEL_LSB = 0;
  localparam int LINE_COUNT_LSB = 3;
  localparam int BUSY_BIT = 6;
  localparam int START_BIT = 7;
  localparam int TEST_BIT = 7;
  localparam int RESULT_LOW_BIT = 7;
  localparam int IRQ_DONE_BIT = 0;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] CLOCK_SETTING_RESET = 8'h00;
  localparam logic [8:0] RESULT_RESET = 9'h000;
  localparam logic [7:0] IRQ_RESET = 8'h00;

  // ****************************************
  // timing: converter clock periods per conversion
  // ****************************************
  localparam int CONV_PERIODS = 76;
  localparam int SAMPLE_PERIODS = 32;
  localparam logic [6:0] CONV_LAST = 7'(CONV_PERIODS - 1);
  localparam logic [6:0] SAMPLE_LAST = 7'(SAMPLE_PERIODS - 1);
  localparam logic [4:0] DIV2_LAST = 5'h01;
  localparam logic [4:0] DIV8_LAST = 5'h07;
  localparam logic [4:0] DIV32_LAST = 5'h1F;

  typedef enum logic [1:0] {
    DIV_BY_2,
    DIV_BY_8,
    DIV_BY_32,
    DIV_UNDEFINED
  } adcsq_div_e;

  typedef enum {
    CONV_IDLE,
    CONV_RESET,
    CONV_SAMPLE,
    CONV_CONVERT
  } adcsq_state_e;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } adcsq_wb_req_s;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } adcsq_wb_rsp_s;
endpackage

//--- hw/adcsq_control.sv
// What this block does
// - eight channels, nine-bit conversion result
// - two result registers are read-only
// - high holds result 8..1, low bit7 result0
// - control bits 2..0 pick the channel
// - control bits 5..3: count of analog lines, 7 giving all eight
// - analog lines lose digital io, pull-high; power on
// - zero line count powers converter off
// - start rising edge resets, sets busy
// - start 0-1-0 begins a conversion
// - end clears busy, sets interrupt request
// - clock setting bits 1..0 pick divider
// - conversion 76 converter clocks, 32 sampling
module adcsq_control (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire adcsq_pkg::adcsq_wb_req_s wb_req_in,
  output adcsq_pkg::adcsq_wb_rsp_s wb_rsp_out,
  input wire logic [8:0] comparator_result_in,
  output logic [2:0] channel_select_out,
  output logic [7:0] analog_line_enable_out,
  output logic [7:0] digital_io_disable_out,
  output logic [7:0] pull_high_disable_out,
  output logic converter_power_out,
  output logic converter_reset_out,
  output logic sample_hold_out,
  output logic converter_clock_tick_out,
  output logic test_mode_out,
  output logic irq_out
);

  // ****************************************
  // registers and state
  // ****************************************
  logic [7:0] converter_control;
  logic [7:0] converter_clock_setting;
  logic [8:0] result;
  logic [7:0] irq_status;
  logic [7:0] irq_mask;
  logic conversion_busy_flag;
  adcsq_pkg::adcsq_state_e state;
  logic [4:0] div_count;
  logic [6:0] period_count;
  logic tick;
  logic done;
  logic ack;
  logic [31:0] rdata;
  logic wr_en;
  logic rd_en;
  logic start_rise;
  logic start_fall;
  logic [7:0] next_control;
  logic [7:0] next_clock_setting;
  logic wr_control;
  logic wr_clock_setting;
  logic wr_status;
  logic wr_mask;
  logic div_wrap;
  logic [2:0] line_count;
  logic [7:0] line_set;

  function automatic logic [7:0] line_mask(input logic [2:0] count);
    logic [7:0] mask;
    mask = 8'h00;
    if (count == 3'h7) begin
      mask = 8'hFF;
    end else begin
      for (int i = 0; i < 7; i++) begin
        if (i < int'(count)) begin
          mask[i] = 1'b1;
        end
      end
    end
    return mask;
  endfunction

  function automatic logic [4:0] div_last(input logic [1:0] sel);
    logic [4:0] last;
    case (adcsq_pkg::adcsq_div_e'(sel))
      adcsq_pkg::DIV_BY_2: last = adcsq_pkg::DIV2_LAST;
      adcsq_pkg::DIV_BY_8: last = adcsq_pkg::DIV8_LAST;
      adcsq_pkg::DIV_BY_32: last = adcsq_pkg::DIV32_LAST;
      default: last = adcsq_pkg::DIV32_LAST;
    endcase
    return last;
  endfunction

  // ****************************************
  // wishbone slave
  // ****************************************
  assign wr_en = wb_req_in.cyc && wb_req_in.stb && wb_req_in.we && !ack && wb_req_in.sel[0];
  assign rd_en = wb_req_in.cyc && wb_req_in.stb && !wb_req_in.we && !ack;

  // ****************************************
  // decoded write strobes
  // ****************************************
  assign wr_control = wr_en && wb_req_in.adr == adcsq_pkg::ADDR_CONTROL;
  assign wr_clock_setting = wr_en && wb_req_in.adr == adcsq_pkg::ADDR_CLOCK_SETTING;
  assign wr_status = wr_en && wb_req_in.adr == adcsq_pkg::ADDR_IRQ_STATUS;
  assign wr_mask = wr_en && wb_req_in.adr == adcsq_pkg::ADDR_IRQ_MASK;

  // ack is registered: every access answers the cycle after it is taken
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      ack <= 1'b0;
    end else begin
      ack <= wb_req_in.cyc && wb_req_in.stb && !ack;
    end
  end

  always_comb begin
    next_control = converter_control;
    next_clock_setting = converter_clock_setting;
    if (wr_control) begin
      next_control = wb_req_in.dat[7:0];
    end
    if (wr_clock_setting) begin
      next_clock_setting = wb_req_in.dat[7:0];
    end
  end

  // write to control register: busy bit is hardware owned
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      converter_control <= adcsq_pkg::CONTROL_RESET;
    end else begin
      converter_control <= next_control;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      converter_clock_setting <= adcsq_pkg::CLOCK_SETTING_RESET;
    end else begin
      converter_clock_setting <= next_clock_setting;
    end
  end

  assign start_rise = next_control[adcsq_pkg::START_BIT]
      && !converter_control[adcsq_pkg::START_BIT];
  assign start_fall = !next_control[adcsq_pkg::START_BIT]
      && converter_control[adcsq_pkg::START_BIT];

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      rdata <= 32'h0000_0000;
    end else if (rd_en) begin
      rdata <= 32'h0000_0000;
      if (wb_req_in.adr == adcsq_pkg::ADDR_RESULT_LOW) begin
        rdata[adcsq_pkg::RESULT_LOW_BIT] <= result[0];
      end else if (wb_req_in.adr == adcsq_pkg::ADDR_RESULT_HIGH) begin
        rdata[7:0] <= result[8:1];
      end else if (wb_req_in.adr == adcsq_pkg::ADDR_CONTROL) begin
        rdata[7:0] <= {converter_control[7], conversion_busy_flag, converter_control[5:0]};
      end else if (wb_req_in.adr == adcsq_pkg::ADDR_CLOCK_SETTING) begin
        rdata[7:0] <= {converter_clock_setting[7], 5'h00, converter_clock_setting[1:0]};
      end else if (wb_req_in.adr == adcsq_pkg::ADDR_IRQ_STATUS) begin
        rdata[7:0] <= irq_status;
      end else if (wb_req_in.adr == adcsq_pkg::ADDR_IRQ_MASK) begin
        rdata[7:0] <= irq_mask;
      end
    end
  end

  assign wb_rsp_out.ack = ack;
  assign wb_rsp_out.dat = rdata;

  // ****************************************
  // converter clock divider
  // ****************************************
  assign div_wrap = div_count >= div_last(converter_clock_setting[1:0]);

  always_ff @(posedge clk_in) begin
    if (srst_in || state == adcsq_pkg::CONV_RESET || div_wrap) begin
      div_count <= 5'h00;
    end else begin
      div_count <= div_count + 5'h01;
    end
  end

  // no converter clock while held in reset, so sampling starts on a full period
  assign tick = (state != adcsq_pkg::CONV_RESET) && div_wrap;

  // ****************************************
  // conversion sequencer
  // ****************************************
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state <= adcsq_pkg::CONV_IDLE;
      period_count <= 7'h00;
    end else if (start_rise) begin
      state <= adcsq_pkg::CONV_RESET;
      period_count <= 7'h00;
    end else begin
      case (state)
        adcsq_pkg::CONV_IDLE: begin
          period_count <= 7'h00;
        end
        adcsq_pkg::CONV_RESET: begin
          if (start_fall) begin
            state <= adcsq_pkg::CONV_SAMPLE;
          end
        end
        adcsq_pkg::CONV_SAMPLE: begin
          if (tick) begin
            period_count <= period_count + 7'h01;
            if (period_count == adcsq_pkg::SAMPLE_LAST) begin
              state <= adcsq_pkg::CONV_CONVERT;
            end
          end
        end
        adcsq_pkg::CONV_CONVERT: begin
          if (tick) begin
            period_count <= period_count + 7'h01;
            if (period_count == adcsq_pkg::CONV_LAST) begin
              state <= adcsq_pkg::CONV_IDLE;
            end
          end
        end
        default: state <= adcsq_pkg::CONV_IDLE;
      endcase
    end
  end

  // a fresh start rise in the final period aborts instead of completing
  assign done = (state == adcsq_pkg::CONV_CONVERT) && tick
      && (period_count == adcsq_pkg::CONV_LAST) && !start_rise;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      conversion_busy_flag <= 1'b0;
    end else if (start_rise) begin
      conversion_busy_flag <= 1'b1;
    end else if (done) begin
      conversion_busy_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      result <= adcsq_pkg::RESULT_RESET;
    end else if (done) begin
      result <= comparator_result_in;
    end
  end

  // ****************************************
  // interrupt status and mask
  // ****************************************
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      irq_status <= adcsq_pkg::IRQ_RESET;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (i == adcsq_pkg::IRQ_DONE_BIT && done) begin
          irq_status[i] <= 1'b1;
        end else if (wr_status && wb_req_in.dat[i]) begin
          irq_status[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      irq_mask <= adcsq_pkg::IRQ_RESET;
    end else if (wr_mask) begin
      irq_mask <= wb_req_in.dat[7:0];
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(irq_status & irq_mask);
    end
  end

  // ****************************************
  // analog front end controls
  // ****************************************
  assign line_count = converter_control[adcsq_pkg::LINE_COUNT_LSB +: 3];
  assign line_set = line_mask(line_count);

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      channel_select_out <= 3'h0;
    end else begin
      channel_select_out <= converter_control[adcsq_pkg::CHANNEL_LSB +: 3];
    end
  end

  // a line given to the converter loses its digital driver and pull-high together
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      analog_line_enable_out <= 8'h00;
      digital_io_disable_out <= 8'h00;
      pull_high_disable_out <= 8'h00;
    end else begin
      analog_line_enable_out <= line_set;
      digital_io_disable_out <= line_set;
      pull_high_disable_out <= line_set;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      converter_power_out <= 1'b0;
    end else begin
      converter_power_out <= |line_count;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      converter_reset_out <= 1'b0;
      sample_hold_out <= 1'b0;
      converter_clock_tick_out <= 1'b0;
    end else begin
      converter_reset_out <= state == adcsq_pkg::CONV_RESET;
      sample_hold_out <= state == adcsq_pkg::CONV_SAMPLE;
      converter_clock_tick_out <= tick;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      test_mode_out <= 1'b0;
    end else begin
      test_mode_out <= converter_clock_setting[adcsq_pkg::TEST_BIT];
    end
  end

endmodule

//--- verif/adcsq_control_monitor.sv
// ****
// bus, port line and sequencing checks
// ****
module adcsq_control_monitor (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire adcsq_pkg::adcsq_wb_req_s wb_req_in,
  input wire adcsq_pkg::adcsq_wb_rsp_s wb_rsp_out,
  input wire logic [7:0] analog_line_enable_out,
  input wire logic [7:0] digital_io_disable_out,
  input wire logic [7:0] pull_high_disable_out,
  input wire logic converter_power_out,
  input wire logic converter_reset_out,
  input wire logic sample_hold_out,
  input wire logic converter_clock_tick_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);
  wire dio_ok = digital_io_disable_out == analog_line_enable_out
    && pull_high_disable_out == analog_line_enable_out;
  sequence s_taken;
    wb_req_in.cyc && wb_req_in.stb && !wb_rsp_out.ack;
  endsequence
  sequence s_answer;
    wb_rsp_out.ack ##1 !wb_rsp_out.ack;
  endsequence
  chk_bus_answer: assert property (s_taken |=> s_answer)
    else $error("bus ack missing or not single");
  chk_low_blank: assert property (
    wb_rsp_out.ack && !$past(wb_req_in.we) && $past(wb_req_in.adr) == adcsq_pkg::ADDR_RESULT_LOW
    |-> wb_rsp_out.dat[6:0] == 7'h00) else $error("low result filler not zero");
  chk_line_follow: assert property (
    dio_ok) else $error("digital or pull-high disable differs from analog lines");
  chk_power_count: assert property (
    converter_power_out == (analog_line_enable_out != 8'h00)) else $error("power mismatch");
  chk_line_shape: assert property (
    (analog_line_enable_out & (analog_line_enable_out + 8'h01)) == 8'h00)
    else $error("analog lines not a low contiguous group");
  chk_tick_pulse: assert property (
    converter_clock_tick_out |=> !converter_clock_tick_out) else $error("tick too long");
  chk_reset_sample: assert property (
    converter_reset_out |-> !sample_hold_out) else $error("sampling during reset");
  chk_sample_min: assert property (
    $rose(sample_hold_out) |-> sample_hold_out[*8]) else $error("sampling cut short");
  chk_reset_leave: assert property (
    $fell(converter_reset_out) |-> ##[0:70] sample_hold_out) else $error("no sampling");
endmodule
bind adcsq_control adcsq_control_monitor i_mon (.clk_in, .srst_in, .wb_req_in, .wb_rsp_out,
  .analog_line_enable_out, .digital_io_disable_out, .pull_high_disable_out,
  .converter_power_out, .converter_reset_out, .sample_hold_out, .converter_clock_tick_out);

//--- verif/tb.sv
// ****
// register level bench
// ****
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 1'h0;
  logic srst_in = 1'h1;
  adcsq_pkg::adcsq_wb_req_s req = '0;
  adcsq_pkg::adcsq_wb_rsp_s rsp;
  logic [8:0] comp = 9'h000;
  logic [2:0] chan;
  logic [7:0] ana;
  logic pwr, crst, samp, tmode, irq;
  logic [15:0] rd;
  int num_errors = 0;
  int checks_done = 0;
  int samp_cnt = 0;
  initial forever #20 clk_in = ~clk_in;
  always @(posedge clk_in) if (samp) samp_cnt <= samp_cnt + 1;
  adcsq_control i_dut (.clk_in, .srst_in, .wb_req_in(req), .wb_rsp_out(rsp),
    .comparator_result_in(comp), .channel_select_out(chan), .analog_line_enable_out(ana),
    .digital_io_disable_out(), .pull_high_disable_out(), .converter_power_out(pwr),
    .converter_reset_out(crst), .sample_hold_out(samp), .converter_clock_tick_out(),
    .test_mode_out(tmode), .irq_out(irq));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("errors=%0d checks=%0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // one classic cycle; read data lands in rd
  task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] wd);
    @(posedge clk_in);
    req <= {1'h1, 1'h1, we, adr, 4'h1, 24'h000000, wd};
    do begin
      @(posedge clk_in);
    end while (rsp.ack !== 1'h1);
    rd = 16'(rsp.dat[7:0]);
    req <= '0;
  endtask
  task automatic convert(input logic [1:0] dv, input logic [8:0] res);
    int n, s0;
    n = 0;
    comp <= res;
    wb(1'h1, adcsq_pkg::ADDR_CLOCK_SETTING, {6'h00, dv});
    wb(1'h1, adcsq_pkg::ADDR_CONTROL, 8'hBD);
    wb(1'h0, adcsq_pkg::ADDR_CONTROL, 8'h00);
    check(rd, 16'h00FD);
    s0 = samp_cnt;
    wb(1'h1, adcsq_pkg::ADDR_CONTROL, 8'h3D);
    do begin
      wb(1'h0, adcsq_pkg::ADDR_CONTROL, 8'h00);
      n++;
    end while (rd[6] !== 1'h0 && n < 3000);
    check(rd, 16'h003D);
    check(16'(samp_cnt - s0), 16'(32 << (2 * dv + 1)));
    wb(1'h0, adcsq_pkg::ADDR_RESULT_HIGH, 8'h00);
    check(rd, 16'(res[8:1]));
    wb(1'h0, adcsq_pkg::ADDR_RESULT_LOW, 8'h00);
    check(rd, 16'({res[0], 7'h00}));
  endtask
  initial begin
    idle(3);
    srst_in <= 1'h0;
    wb(1'h0, adcsq_pkg::ADDR_CONTROL, 8'h00);
    check(rd, 16'h0000);
    wb(1'h1, adcsq_pkg::ADDR_CLOCK_SETTING, 8'h7F);
    wb(1'h0, adcsq_pkg::ADDR_CLOCK_SETTING, 8'h00);
    check(rd, 16'h0003);
    check(16'(tmode), 16'h0000);
    wb(1'h1, adcsq_pkg::ADDR_RESULT_HIGH, 8'hFF);
    wb(1'h0, adcsq_pkg::ADDR_RESULT_HIGH, 8'h00);
    check(rd, 16'h0000);
    wb(1'h0, 8'h30, 8'h00);
    check(rd, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      wb(1'h1, adcsq_pkg::ADDR_CONTROL, 8'(i * 9));
      idle(2);
      check(16'(chan), 16'(i));
      check(16'(ana), (i == 7) ? 16'h00FF : 16'((1 << i) - 1));
      check(16'(pwr), 16'(i != 0));
    end
    for (int d = 0; d < 4; d++) begin
      wb(1'h1, adcsq_pkg::ADDR_IRQ_MASK, 8'(d != 3));
      convert(2'(d % 3), 9'(9'h0A5 << d));
      idle(2);
      check(16'(irq), 16'(d != 3));
      wb(1'h0, adcsq_pkg::ADDR_IRQ_STATUS, 8'h00);
      check(rd, 16'h0001);
      wb(1'h1, adcsq_pkg::ADDR_IRQ_STATUS, 8'h01);
      idle(2);
      check(16'(irq), 16'h0000);
    end
    wb(1'h1, adcsq_pkg::ADDR_CONTROL, 8'hBD);
    wb(1'h1, adcsq_pkg::ADDR_CONTROL, 8'h3D);
    idle(10);
    wb(1'h1, adcsq_pkg::ADDR_CONTROL, 8'hBD);
    idle(2);
    check(16'({crst, samp}), 16'h0002);
    convert(2'h0, 9'h13C);
    give_verdict();
  end
  initial begin
    idle(30000);
    num_errors++;
    give_verdict();
  end
endmodule
